// ---- src/avsc_axil.sv ----
// AXI4-Lite slave front end for the converter control registers
`timescale 1ns/1ns
module avsc_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output avsc_pkg::avsc_req_t req,
  input wire logic [31:0] rd_data,
  input wire logic rd_err,
  input wire logic wr_err
);
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic rd_go;

  assign wr_go = aw_held_r && w_held_r && !bvalid;
  assign rd_go = arvalid && arready;

  // ****************************************
  // Write channel: address and data taken in either order
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else if (ce) begin
      awready <= !aw_held_r && !awready && awvalid;
      wready <= !w_held_r && !wready && wvalid;
      if (awvalid && awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_err ? 2'h2 : 2'h0;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read channel: data sampled in the cycle the address is taken
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'h0;
    end else if (ce) begin
      arready <= !arready && !rvalid && arvalid;
      if (rd_go) begin
        rvalid <= 1'b1;
        rdata <= rd_data;
        rresp <= rd_err ? 2'h2 : 2'h0;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    req.wr = wr_go && ce;
    req.rd = rd_go && ce;
    req.waddr = awaddr_r;
    req.raddr = araddr;
    req.wdata = wdata_r;
    req.wstrb = wstrb_r;
  end
endmodule // avsc_axil

// ---- src/avsc_consts.svh ----
// Offsets, field positions, reset values and counts of the converter control block
`ifndef AVSC_CONSTS_SVH
`define AVSC_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define AVSC_OFF_STATUS 8'h00
`define AVSC_OFF_MASK 8'h04
`define AVSC_OFF_MODE 8'h08
`define AVSC_OFF_CONFIG 8'h0C
`define AVSC_OFF_RATE 8'h10
`define AVSC_OFF_HVCFG 8'h14
`define AVSC_OFF_CUR 8'h18
`define AVSC_OFF_VOLT 8'h1C
`define AVSC_OFF_TEMP 8'h20

// ****************************************
// Field positions
// ****************************************
`define AVSC_STA_CUR_RDY 0
`define AVSC_STA_VOLT_RDY 1
`define AVSC_STA_TEMP_RDY 2
`define AVSC_STA_OVR 3
`define AVSC_STA_THR 4
`define AVSC_STA_CUR_ERR 12
`define AVSC_STA_VOLT_ERR 13
`define AVSC_STA_TEMP_ERR 14
`define AVSC_STA_CAL 15
`define AVSC_CFG_CUR_EN 0
`define AVSC_CFG_VT_EN 1
`define AVSC_CFG_SEL_LO 3
`define AVSC_CFG_GND_CONN 7
`define AVSC_MDE_GND_RES 6
`define AVSC_HV_ATTN_EN 7

// ****************************************
// Reset values and limits
// ****************************************
`define AVSC_RST_CONFIG 8'h03
`define AVSC_RST_MODE 8'h00
`define AVSC_RST_MASK 8'h00
`define AVSC_RST_HVCFG 8'h00
`define AVSC_RST_RATE 16'h0000
`define AVSC_POS_FULL 16'h7FFF
`define AVSC_NEG_FULL 16'h8000
`define AVSC_SETTLE_CONV 2'h3

`endif

// ---- src/avsc_pkg.sv ----
// Types shared by the converter control block
package avsc_pkg;

  // One conversion delivered by a modulator and its filter
  typedef struct packed {
    logic valid;
    logic [15:0] data;
    logic over;
    logic under;
  } avsc_conv_t;

  // Register access request from the bus slave
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] waddr;
    logic [7:0] raddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } avsc_req_t;

  // Input source of the voltage/temperature converter
  typedef enum logic [1:0] {
    AVSC_SRC_EXT_VOLT,
    AVSC_SRC_EXT_TEMP,
    AVSC_SRC_CHIP_TEMP
  } avsc_src_t;

endpackage

// ---- src/avsc_top.sv ----
// Voltage/temperature channel control, result registers and converter interrupt
`timescale 1ns/1ns
`include "avsc_consts.svh"
module avsc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire avsc_pkg::avsc_conv_t cur_conv,
  input wire avsc_pkg::avsc_conv_t vt_conv,
  input wire logic cal_done,
  input wire logic ovr_event,
  input wire logic thr_event,
  input wire logic core_pd,
  output logic [1:0] vt_source_r,
  output logic [15:0] filter_rate_r,
  output logic attn_en_r,
  output logic cur_en_r,
  output logic vt_en_r,
  output logic gsw_direct_r,
  output logic gsw_resistor_r,
  output logic irq_r
);
  avsc_pkg::avsc_req_t req;
  logic [31:0] rd_data;
  logic rd_err;
  logic wr_err;
  logic [7:0] config_r;
  logic [7:0] mode_r;
  logic [7:0] mask_r;
  logic [7:0] hvcfg_r;
  logic [15:0] status_r;
  logic [15:0] cur_res_r;
  logic [15:0] volt_res_r;
  logic [15:0] temp_res_r;
  logic [1:0] settle_r;
  logic pd_meta_r;
  logic pd_sync_r;
  logic [7:0] lo_set;
  logic [7:0] lo_clr;
  logic rdy_clear;
  logic vt_ok;
  logic vt_to_volt;
  logic cur_load;
  logic volt_load;
  logic temp_load;
  logic [15:0] cur_val;
  logic [15:0] vt_val;
  logic [7:0] cfg_nxt;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr[7:2] == off[7:2]);
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = hit(addr, `AVSC_OFF_STATUS) || hit(addr, `AVSC_OFF_MASK) ||
             hit(addr, `AVSC_OFF_MODE) || hit(addr, `AVSC_OFF_CONFIG) ||
             hit(addr, `AVSC_OFF_RATE) || hit(addr, `AVSC_OFF_HVCFG) ||
             hit(addr, `AVSC_OFF_CUR) || hit(addr, `AVSC_OFF_VOLT) ||
             hit(addr, `AVSC_OFF_TEMP);
  endfunction

  // Clamp out-of-range conversions to full scale
  function automatic logic [15:0] clamp(input avsc_pkg::avsc_conv_t c);
    if (c.over) begin
      clamp = `AVSC_POS_FULL;
    end else if (c.under) begin
      clamp = `AVSC_NEG_FULL;
    end else begin
      clamp = c.data;
    end
  endfunction

  function automatic logic wr_to(input avsc_pkg::avsc_req_t r, input logic [7:0] off);
    wr_to = r.wr && hit(r.waddr, off) && r.wstrb[0];
  endfunction

  // ****************************************
  // Bus slave
  // ****************************************
  avsc_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .req(req),
    .rd_data(rd_data),
    .rd_err(rd_err),
    .wr_err(wr_err)
  );

  assign rd_err = !mapped(req.raddr);
  assign wr_err = !mapped(req.waddr);

  always_comb begin
    rd_data = 32'h00000000;
    if (hit(req.raddr, `AVSC_OFF_STATUS)) begin
      rd_data[15:0] = status_r;
    end else if (hit(req.raddr, `AVSC_OFF_MASK)) begin
      rd_data[7:0] = mask_r;
    end else if (hit(req.raddr, `AVSC_OFF_MODE)) begin
      rd_data[7:0] = mode_r;
    end else if (hit(req.raddr, `AVSC_OFF_CONFIG)) begin
      rd_data[7:0] = config_r;
    end else if (hit(req.raddr, `AVSC_OFF_RATE)) begin
      rd_data[15:0] = filter_rate_r;
    end else if (hit(req.raddr, `AVSC_OFF_HVCFG)) begin
      rd_data[7:0] = hvcfg_r;
    end else if (hit(req.raddr, `AVSC_OFF_CUR)) begin
      rd_data[15:0] = cur_res_r;
    end else if (hit(req.raddr, `AVSC_OFF_VOLT)) begin
      rd_data[15:0] = volt_res_r;
    end else if (hit(req.raddr, `AVSC_OFF_TEMP)) begin
      rd_data[15:0] = temp_res_r;
    end
  end

  // ****************************************
  // Power-down level from the core domain
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_meta_r <= 1'b0;
      pd_sync_r <= 1'b0;
    end else if (ce) begin
      pd_meta_r <= core_pd;
      pd_sync_r <= pd_meta_r;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  assign cfg_nxt = wr_to(req, `AVSC_OFF_CONFIG) ? req.wdata[7:0] : config_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_r <= `AVSC_RST_CONFIG;
      mode_r <= `AVSC_RST_MODE;
      mask_r <= `AVSC_RST_MASK;
      hvcfg_r <= `AVSC_RST_HVCFG;
      filter_rate_r <= `AVSC_RST_RATE;
    end else if (ce) begin
      config_r <= cfg_nxt;
      if (wr_to(req, `AVSC_OFF_MODE)) begin
        mode_r <= req.wdata[7:0];
      end
      if (wr_to(req, `AVSC_OFF_MASK)) begin
        mask_r <= req.wdata[7:0];
      end
      if (wr_to(req, `AVSC_OFF_HVCFG)) begin
        hvcfg_r <= req.wdata[7:0];
      end
      // Rate word steers the decimation filter
      if (req.wr && hit(req.waddr, `AVSC_OFF_RATE)) begin
        if (req.wstrb[0]) begin
          filter_rate_r[7:0] <= req.wdata[7:0];
        end
        if (req.wstrb[1]) begin
          filter_rate_r[15:8] <= req.wdata[15:8];
        end
      end
    end
  end

  // ****************************************
  // Analog controls
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vt_source_r <= 2'h0;
      attn_en_r <= 1'b0;
      cur_en_r <= 1'b0;
      vt_en_r <= 1'b0;
      gsw_direct_r <= 1'b0;
      gsw_resistor_r <= 1'b0;
    end else if (ce) begin
      // Reserved code falls back to the external voltage input
      if (config_r[`AVSC_CFG_SEL_LO +: 2] == 2'h3) begin
        vt_source_r <= 2'(avsc_pkg::AVSC_SRC_EXT_VOLT);
      end else begin
        vt_source_r <= config_r[`AVSC_CFG_SEL_LO +: 2];
      end
      attn_en_r <= hvcfg_r[`AVSC_HV_ATTN_EN];
      cur_en_r <= config_r[`AVSC_CFG_CUR_EN];
      vt_en_r <= config_r[`AVSC_CFG_VT_EN];
      // Both low means the pin floats
      gsw_direct_r <= config_r[`AVSC_CFG_GND_CONN] && !mode_r[`AVSC_MDE_GND_RES];
      gsw_resistor_r <= config_r[`AVSC_CFG_GND_CONN] && mode_r[`AVSC_MDE_GND_RES];
    end
  end

  // ****************************************
  // Settling after a source switch
  // ****************************************
  // Filter still holds samples of the old input for two conversions
  assign vt_ok = vt_conv.valid && vt_en_r && (settle_r >= `AVSC_SETTLE_CONV - 2'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_r <= 2'h0;
    end else if (ce) begin
      if (cfg_nxt[`AVSC_CFG_SEL_LO +: 2] != config_r[`AVSC_CFG_SEL_LO +: 2]) begin
        settle_r <= 2'h0;
      end else if (vt_conv.valid && vt_en_r && settle_r != `AVSC_SETTLE_CONV) begin
        settle_r <= settle_r + 2'h1;
      end
    end
  end

  // ****************************************
  // Result registers
  // ****************************************
  assign vt_to_volt = (vt_source_r == 2'(avsc_pkg::AVSC_SRC_EXT_VOLT));
  assign cur_val = clamp(cur_conv);
  assign vt_val = clamp(vt_conv);
  // Held result is kept until its ready flag is cleared unless powered down
  assign cur_load = cur_conv.valid && cur_en_r &&
                    (!status_r[`AVSC_STA_CUR_RDY] || pd_sync_r);
  assign volt_load = vt_ok && vt_to_volt &&
                     (!status_r[`AVSC_STA_VOLT_RDY] || pd_sync_r);
  assign temp_load = vt_ok && !vt_to_volt &&
                     (!status_r[`AVSC_STA_TEMP_RDY] || pd_sync_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_res_r <= 16'h0000;
      volt_res_r <= 16'h0000;
      temp_res_r <= 16'h0000;
    end else if (ce) begin
      if (cur_load) begin
        cur_res_r <= cur_val;
      end
      if (volt_load) begin
        volt_res_r <= vt_val;
      end
      if (temp_load) begin
        temp_res_r <= vt_val;
      end
    end
  end

  // ****************************************
  // Status lower byte: sticky interrupt sources
  // ****************************************
  // Current read always clears; voltage or temperature read only with current off
  assign rdy_clear = req.rd && (hit(req.raddr, `AVSC_OFF_CUR) ||
                     (!cur_en_r && (hit(req.raddr, `AVSC_OFF_VOLT) ||
                                    hit(req.raddr, `AVSC_OFF_TEMP))));

  always_comb begin
    lo_set = 8'h00;
    lo_set[`AVSC_STA_CUR_RDY] = cur_load;
    lo_set[`AVSC_STA_VOLT_RDY] = volt_load;
    lo_set[`AVSC_STA_TEMP_RDY] = temp_load;
    lo_set[`AVSC_STA_OVR] = ovr_event;
    lo_set[`AVSC_STA_THR] = thr_event;
    lo_clr = 8'h00;
    if (wr_to(req, `AVSC_OFF_STATUS)) begin
      lo_clr = req.wdata[7:0];
    end
    if (rdy_clear) begin
      lo_clr[`AVSC_STA_CUR_RDY] = 1'b1;
      lo_clr[`AVSC_STA_VOLT_RDY] = 1'b1;
      lo_clr[`AVSC_STA_TEMP_RDY] = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_lo
      // An event in the clearing cycle is kept
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          status_r[gi] <= 1'b0;
        end else if (ce) begin
          if (lo_set[gi]) begin
            status_r[gi] <= 1'b1;
          end else if (lo_clr[gi]) begin
            status_r[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Status upper byte: flags only
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r[15:8] <= 8'h00;
    end else if (ce) begin
      if (cur_load) begin
        status_r[`AVSC_STA_CUR_ERR] <= cur_conv.over || cur_conv.under;
      end
      if (volt_load) begin
        status_r[`AVSC_STA_VOLT_ERR] <= vt_conv.over || vt_conv.under;
      end
      if (temp_load) begin
        status_r[`AVSC_STA_TEMP_ERR] <= vt_conv.over || vt_conv.under;
      end
      if (cal_done) begin
        status_r[`AVSC_STA_CAL] <= 1'b1;
      end else if (wr_to(req, `AVSC_OFF_MODE)) begin
        status_r[`AVSC_STA_CAL] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Interrupt request
  // ****************************************
  // Upper byte deliberately left out of the OR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= |(status_r[7:0] & mask_r);
    end
  end
endmodule // avsc_top

// ---- test/avsc_top_checker.sv ----
// Port-level assertions for the converter control block
`timescale 1ns/1ns
module avsc_top_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire avsc_pkg::avsc_conv_t cur_conv,
  input wire avsc_pkg::avsc_conv_t vt_conv,
  input wire logic ovr_event,
  input wire logic thr_event,
  input wire logic [1:0] vt_source_r,
  input wire logic [15:0] filter_rate_r,
  input wire logic attn_en_r,
  input wire logic gsw_direct_r,
  input wire logic gsw_resistor_r,
  input wire logic irq_r
);
  logic low_evt;
  assign low_evt = cur_conv.valid | vt_conv.valid | ovr_event | thr_event;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ****************************************
  // Settings move only with an answered write and hold legal values
  // ****************************************
  // Pin settings follow their register one edge later, so bvalid rose one edge before
  a_src_by_write: assert property (
    $changed(vt_source_r) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("source select moved without a write");
  a_src_legal: assert property (vt_source_r != 2'h3)
    else $error("source select holds an unused code");
  a_rate_by_write: assert property ($changed(filter_rate_r) |-> $rose(s_axi_bvalid))
    else $error("rate word moved without a write");
  a_attn_by_write: assert property (
    $changed(attn_en_r) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("attenuator enable moved without a write");
  a_gsw_by_write: assert property (
    $changed({gsw_direct_r, gsw_resistor_r}) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("ground switch moved without a write");
  a_gsw_excl: assert property (!(gsw_direct_r && gsw_resistor_r))
    else $error("ground switch direct and resistor paths both on");
  // ****************************************
  // Interrupt cause and release
  // ****************************************
  // Upper-byte flags are not causes, so a lone calibration pulse must not raise it
  a_irq_cause: assert property (
    $rose(irq_r) |-> $past(low_evt, 2) || $past(s_axi_bvalid))
    else $error("interrupt rose without a lower-byte event or mask write");
  a_irq_release: assert property (
    $fell(irq_r) |-> $past(s_axi_bvalid) || $past(s_axi_rvalid))
    else $error("interrupt dropped without a clearing access");
endmodule // avsc_top_checker

bind avsc_top avsc_top_checker chk_u (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_rvalid, .cur_conv, .vt_conv, .ovr_event,
  .thr_event, .vt_source_r, .filter_rate_r, .attn_en_r, .gsw_direct_r, .gsw_resistor_r, .irq_r
);

// ---- test/avsc_top_test.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`include "avsc_consts.svh"
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      error_cnt++; \
      $display("BAD t=%0t got %0h exp %0h", $time, (g), (e)); \
    end \
  end
module avsc_top_test;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, core_pd = 1'b0;
  logic cal_done = 1'b0, ovr_event = 1'b0, thr_event = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_val;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp, vt_source_r;
  avsc_pkg::avsc_conv_t cur_conv = '0, vt_conv = '0;
  logic [15:0] filter_rate_r;
  logic attn_en_r, cur_en_r, vt_en_r, gsw_direct_r, gsw_resistor_r, irq_r;
  int error_cnt = 0;
  int tests_run = 0;

  avsc_top dut_u (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cur_conv, .vt_conv, .cal_done, .ovr_event, .thr_event, .core_pd,
    .vt_source_r, .filter_rate_r, .attn_en_r, .cur_en_r, .vt_en_r, .gsw_direct_r,
    .gsw_resistor_r, .irq_r
  );

  always #25 aclk = ~aclk;

  // ****************************************
  // Bus and stimulus helpers
  // ****************************************
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic stuck(input int n);
    if (n == 64) begin
      `CHK(1'b0, 1'b1)
      give_verdict();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) break;
    end
    stuck(n);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Pin settings land one edge after the register, let them settle before any check
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) break;
    end
    stuck(n);
    rd_val = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a);
    `CHK(rd_val, e)
  endtask

  // Conversion word is {valid, data, over, under}
  task automatic conv(input bit vt, input logic [15:0] d, input logic [1:0] ou);
    @(posedge aclk);
    if (vt) vt_conv <= avsc_pkg::avsc_conv_t'({1'b1, d, ou});
    else cur_conv <= avsc_pkg::avsc_conv_t'({1'b1, d, ou});
    @(posedge aclk);
    vt_conv <= '0;
    cur_conv <= '0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic ev_pulse(input logic [2:0] v);
    @(posedge aclk);
    {cal_done, ovr_event, thr_event} <= v;
    @(posedge aclk);
    {cal_done, ovr_event, thr_event} <= 3'h0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic done(input string name);
    $display("test %s ended: comparisons %0d, mismatches %0d", name, tests_run, error_cnt);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    `CHK({vt_source_r, filter_rate_r, attn_en_r, gsw_direct_r, gsw_resistor_r}, 21'h0)
    `CHK({cur_en_r, vt_en_r, irq_r}, 3'h6)
    rd_chk(`AVSC_OFF_CONFIG, {24'h0, `AVSC_RST_CONFIG});
    rd_chk(`AVSC_OFF_STATUS, 32'h0);
    rd_chk(`AVSC_OFF_MASK, {24'h0, `AVSC_RST_MASK});
    rd_chk(`AVSC_OFF_HVCFG, {24'h0, `AVSC_RST_HVCFG});
    axi_wr(`AVSC_OFF_CUR, 32'hFFFF);
    rd_chk(`AVSC_OFF_CUR, 32'h0);
    axi_rd(8'h24);
    `CHK({rd_resp, rd_val}, 34'h200000000)
    axi_wr(8'h24, 32'hFFFFFFFF);
    `CHK(wr_resp, 2'h2)
    done("reset");
  endtask

  task automatic t_cfg();
    for (int i = 0; i < 4; i++) begin
      axi_wr(`AVSC_OFF_CONFIG, 32'h03 | (i << 3));
      `CHK(vt_source_r, (i == 3) ? 2'h0 : 2'(i))
    end
    for (int i = 0; i < 4; i++) begin
      axi_wr(`AVSC_OFF_CONFIG, (i > 1) ? 32'h83 : 32'h03);
      axi_wr(`AVSC_OFF_MODE, i[0] ? 32'h40 : 32'h00);
      `CHK({gsw_direct_r, gsw_resistor_r}, (i == 2) ? 2'h2 : (i == 3) ? 2'h1 : 2'h0)
    end
    axi_wr(`AVSC_OFF_HVCFG, 32'h80);
    `CHK(attn_en_r, 1'b1)
    axi_wr(`AVSC_OFF_HVCFG, 32'h7F);
    `CHK(attn_en_r, 1'b0)
    axi_wr(`AVSC_OFF_RATE, 32'hBF1D);
    `CHK(filter_rate_r, 16'hBF1D)
    rd_chk(`AVSC_OFF_RATE, 32'hBF1D);
    done("config");
  endtask

  task automatic t_settle();
    axi_wr(`AVSC_OFF_CONFIG, 32'h0B);
    conv(1, 16'h0001, 2'b00);
    conv(1, 16'h0002, 2'b00);
    rd_chk(`AVSC_OFF_STATUS, 32'h0);
    conv(1, 16'h0003, 2'b00);
    rd_chk(`AVSC_OFF_STATUS, 32'h4);
    conv(1, 16'h0004, 2'b00);
    rd_chk(`AVSC_OFF_TEMP, 32'h3);
    rd_chk(`AVSC_OFF_STATUS, 32'h4);
    rd_chk(`AVSC_OFF_CUR, 32'h0);
    rd_chk(`AVSC_OFF_STATUS, 32'h0);
    done("settle");
  endtask

  task automatic t_clamp();
    conv(0, 16'h1234, 2'b00);
    conv(0, 16'h5678, 2'b00);
    rd_chk(`AVSC_OFF_CUR, 32'h1234);
    conv(0, 16'h0000, 2'b10);
    rd_chk(`AVSC_OFF_STATUS, 32'h1001);
    rd_chk(`AVSC_OFF_CUR, {16'h0, `AVSC_POS_FULL});
    conv(0, 16'h0000, 2'b01);
    rd_chk(`AVSC_OFF_CUR, {16'h0, `AVSC_NEG_FULL});
    conv(0, 16'h0055, 2'b00);
    rd_chk(`AVSC_OFF_STATUS, 32'h1);
    rd_chk(`AVSC_OFF_CUR, 32'h55);
    done("clamp");
  endtask

  task automatic t_irq();
    ev_pulse(3'b001);
    rd_chk(`AVSC_OFF_STATUS, 32'h10);
    `CHK(irq_r, 1'b0)
    axi_wr(`AVSC_OFF_MASK, 32'h10);
    repeat (2) @(posedge aclk);
    `CHK(irq_r, 1'b1)
    ev_pulse(3'b100);
    axi_wr(`AVSC_OFF_STATUS, 32'h10);
    axi_wr(`AVSC_OFF_MASK, 32'hFF);
    repeat (2) @(posedge aclk);
    `CHK(irq_r, 1'b0)
    rd_chk(`AVSC_OFF_STATUS, 32'h8000);
    axi_wr(`AVSC_OFF_MODE, 32'h00);
    rd_chk(`AVSC_OFF_STATUS, 32'h0);
    ev_pulse(3'b010);
    `CHK(irq_r, 1'b1)
    axi_wr(`AVSC_OFF_STATUS, 32'h08);
    repeat (2) @(posedge aclk);
    `CHK(irq_r, 1'b0)
    done("interrupt");
  endtask

  task automatic t_pd();
    axi_wr(`AVSC_OFF_CONFIG, 32'h02);
    `CHK({cur_en_r, vt_en_r}, 2'b01)
    conv(1, 16'h000A, 2'b00);
    conv(1, 16'h000B, 2'b00);
    conv(1, 16'h000C, 2'b00);
    rd_chk(`AVSC_OFF_STATUS, 32'h2);
    // Voltage result read with current off, so this read alone clears the ready flags
    rd_chk(`AVSC_OFF_VOLT, 32'hC);
    rd_chk(`AVSC_OFF_STATUS, 32'h0);
    core_pd <= 1'b1;
    repeat (4) @(posedge aclk);
    conv(1, 16'h000D, 2'b00);
    conv(1, 16'h000E, 2'b00);
    rd_chk(`AVSC_OFF_VOLT, 32'hE);
    core_pd <= 1'b0;
    done("power_down");
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_cfg();
    t_settle();
    t_clamp();
    t_irq();
    t_pd();
    give_verdict();
  end
endmodule // avsc_top_test
